// >>> src/local_peripheral_bus_master.v
/*
  Master of the byte-wide local peripheral bus that reaches an external
  physical-layer device. A request port starts one read or write; the
  sequencer drives select, direction, address and write data.
  Assumes the clock is the PCI clock and all inputs are synchronous.
*/
`timescale 1ns/1ps
`include "lpb_consts.vh"

module local_peripheral_bus_master #(
  parameter ADDR_W = `LPB_ADDR_W,
  parameter DATA_W = `LPB_DATA_W,
  parameter WRITE_CYCLES = `LPB_WRITE_CYCLES,
  parameter READ_TIMEOUT = `LPB_READ_TIMEOUT
) (
  // Clock and reset.
  input wire clk_in,
  input wire rst_n_in,
  // Request port from the host side.
  input wire req_valid_in,
  input wire req_read_in,
  input wire [ADDR_W-1:0] req_addr_in,
  input wire [DATA_W-1:0] req_wdata_in,
  output wire req_ready_out,
  // Completion port.
  output reg done_out,
  output reg timeout_out,
  output reg [DATA_W-1:0] rdata_out,
  // Peripheral bus pins.
  output reg periph_select_n_out,
  output reg periph_read_not_write_out,
  output reg [ADDR_W-1:0] periph_addr_out,
  input wire [DATA_W-1:0] periph_data_in,
  output reg [DATA_W-1:0] periph_data_out,
  output reg periph_data_oe_out,
  input wire periph_ready_n_in
);

  // Limits handed to the counter. It counts from zero, so the last
  // select-low cycle is reached at one less than the cycle count.
  localparam integer WRITE_LIMIT_I = WRITE_CYCLES - 1;
  localparam integer READ_LIMIT_I = READ_TIMEOUT - 1;
  localparam [`LPB_CNT_W-1:0] WRITE_LIMIT = WRITE_LIMIT_I[`LPB_CNT_W-1:0];
  localparam [`LPB_CNT_W-1:0] READ_LIMIT = READ_LIMIT_I[`LPB_CNT_W-1:0];

  // Sequencer states, binary coded. The hold state exists only to keep the
  // address and the write data on the pins for one cycle after select rises.
  localparam [2:0] ST_IDLE = `LPB_ST_IDLE;
  localparam [2:0] ST_SETUP = `LPB_ST_SETUP;
  localparam [2:0] ST_READ = `LPB_ST_READ;
  localparam [2:0] ST_WRITE = `LPB_ST_WRITE;
  localparam [2:0] ST_HOLD = `LPB_ST_HOLD;

  reg [2:0] state;
  reg [2:0] next_state;
  reg is_read;
  wire cnt_done;
  wire cnt_clear;
  wire cnt_run;
  wire [`LPB_CNT_W-1:0] cnt_limit;
  wire take_req;
  wire read_end;

  //////////////////////////////////////////////////////////////////////////
  // Cycle counter: runs while select is low, restarted in setup. One counter
  // serves both directions, so the limit follows the cycle in flight.
  // The limit is chosen from a flop that is stable before setup clears it.
  assign cnt_clear = (state == ST_SETUP);
  assign cnt_run = (state == ST_READ) || (state == ST_WRITE);
  assign cnt_limit = is_read ? READ_LIMIT : WRITE_LIMIT;

  lpb_cycle_counter #(
    .CNT_W(`LPB_CNT_W)
  ) u_lpb_cycle_counter (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(cnt_clear),
    .count_in(cnt_run),
    .limit_in(cnt_limit),
    .done_out(cnt_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Request handshake. New requests are taken only when the bus is idle;
  // a request held while busy simply waits, it is never lost or merged.
  assign req_ready_out = (state == ST_IDLE);
  assign take_req = req_valid_in && req_ready_out;

  // A read ends on ready low or on the time-out, whichever comes first.
  // Ready is a level from the peripheral and is taken as synchronous.
  assign read_end = (!periph_ready_n_in) || cnt_done;

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic of the sequencer.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_req) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // One cycle of setup so direction, address and data lead select.
        next_state = is_read ? ST_READ : ST_WRITE;
      end
      ST_READ: begin
        if (read_end) begin
          next_state = ST_HOLD;
        end
      end
      ST_WRITE: begin
        // Ready is ignored on writes so slow peripherals always get 8 cycles.
        if (cnt_done) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // The address stays on the pins through this cycle before a new take.
        next_state = ST_IDLE;
      end
      default: begin
        // Unused codes fall back to idle rather than locking the bus up.
        next_state = ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register and the direction of the cycle in flight. The direction
  // is kept apart from the pin so the pin may idle high between cycles.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      is_read <= 1'b0;
    end else begin
      state <= next_state;
      if (take_req) begin
        is_read <= req_read_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Completion port. Done and time-out are single-cycle pulses on the edge
  // that raises select; read data is held until the next read ends, so a
  // slow host can still pick it up after the pulse has gone.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_out <= 1'b0;
      timeout_out <= 1'b0;
      rdata_out <= {DATA_W{1'b0}};
    end else begin
      done_out <= 1'b0;
      timeout_out <= 1'b0;
      if ((state == ST_READ) && read_end) begin
        // Data sampled on the edge that terminates the cycle.
        rdata_out <= periph_data_in;
        timeout_out <= periph_ready_n_in;
        done_out <= 1'b1;
      end
      if ((state == ST_WRITE) && cnt_done) begin
        done_out <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Peripheral bus pins, all from flip-flops so the pins never glitch.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      periph_select_n_out <= `LPB_SELECT_IDLE;
      periph_read_not_write_out <= `LPB_RNW_IDLE;
      periph_addr_out <= {ADDR_W{1'b0}};
      periph_data_out <= {DATA_W{1'b0}};
      periph_data_oe_out <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take_req) begin
            // Address, direction and write data set up while select is high.
            periph_read_not_write_out <= req_read_in;
            periph_addr_out <= req_addr_in;
            periph_data_out <= req_wdata_in;
            periph_data_oe_out <= !req_read_in;
          end
        end
        ST_SETUP: begin
          periph_select_n_out <= 1'b0;
        end
        ST_READ: begin
          if (read_end) begin
            periph_select_n_out <= 1'b1;
          end
        end
        ST_WRITE: begin
          if (cnt_done) begin
            periph_select_n_out <= 1'b1;
          end
        end
        ST_HOLD: begin
          // Address and data are kept one cycle past select rising; the
          // address is then left in place, not released, until the next take.
          periph_data_oe_out <= 1'b0;
          periph_read_not_write_out <= `LPB_RNW_IDLE;
        end
        default: begin
          periph_select_n_out <= `LPB_SELECT_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> src/lpb_consts.vh
/*
  Constants for the local peripheral bus master: bus widths, the fixed
  write strobe length, the read time-out and the state codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LPB_CONSTS_VH
`define LPB_CONSTS_VH

// Address and data widths of the peripheral bus.
`define LPB_ADDR_W 12
`define LPB_DATA_W 8

// Cycles the select stays low on a write, and the read time-out.
`define LPB_WRITE_CYCLES 8
`define LPB_READ_TIMEOUT 8
`define LPB_CNT_W 4

// State codes of the cycle sequencer.
`define LPB_ST_IDLE 3'h0
`define LPB_ST_SETUP 3'h1
`define LPB_ST_READ 3'h2
`define LPB_ST_WRITE 3'h3
`define LPB_ST_HOLD 3'h4

// Reset values of the bus outputs.
`define LPB_SELECT_IDLE 1'h1
`define LPB_RNW_IDLE 1'h1

`endif

// >>> src/lpb_cycle_counter.v
/*
  Cycle counter for the peripheral bus master: cleared on start, counts
  while enabled, and flags when the programmed count has been reached.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "lpb_consts.vh"

module lpb_cycle_counter #(
  parameter CNT_W = `LPB_CNT_W
) (
  // Clock and reset.
  input wire clk_in,
  input wire rst_n_in,
  // Control.
  input wire clear_in,
  input wire count_in,
  input wire [CNT_W-1:0] limit_in,
  // Status.
  output wire done_out
);

  reg [CNT_W-1:0] count;

  // Count up from zero; a clear wins so every cycle starts fresh.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= {CNT_W{1'b0}};
    end else if (clear_in) begin
      count <= {CNT_W{1'b0}};
    end else if (count_in && !done_out) begin
      count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Done once the count reaches the limit.
  assign done_out = (count == limit_in);

endmodule

// >>> bench/lpb_periph_model.sv
/* Behavioural byte-wide peripheral on the bus far side.
   Assumes the bench sets the ready latency; 0 means never ready. */
`timescale 1ns/1ps
module lpb_periph_model (
  // Bus pins seen from the peripheral, and the ready latency set by the bench.
  input wire clk_in,
  input wire sel_n_in,
  input wire [11:0] addr_in,
  input wire [3:0] lat_in,
  output logic ready_n_out,
  output logic [7:0] data_out
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] junk = 8'h00;
  // Idle data changes every cycle so a late capture cannot pass by luck.
  always @(posedge clk_in) begin
    cnt <= sel_n_in ? 4'h0 : cnt + 4'h1;
    junk <= junk + 8'h3b;
  end
  // Ready comes with valid data, even on writes, which must ignore it.
  assign ready_n_out = sel_n_in || lat_in == 4'h0 || cnt < lat_in;
  assign data_out = sel_n_in ? junk : addr_in[7:0] ^ 8'h5a;
endmodule

// >>> bench/lpb_master_chk.sv
/* Pin-level checker for the peripheral bus master.
   Assumes it is bound to the master's top module. */
`timescale 1ns/1ps
module lpb_master_chk (
  // Watched ports.
  input wire clk_in,
  input wire rst_n_in,
  input wire done_out,
  input wire timeout_out,
  input wire periph_select_n_out,
  input wire periph_read_not_write_out,
  input wire [11:0] periph_addr_out,
  input wire [7:0] periph_data_out,
  input wire periph_data_oe_out,
  input wire periph_ready_n_in
);
  // Short aliases keep every property but chk_data_setup on one line.
  wire s = periph_select_n_out;
  wire r = periph_read_not_write_out;
  wire [11:0] a = periph_addr_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_read_dir: assert property ($fell(s) && r |-> $past(r)) else $error("dir");
  chk_ready_end: assert property (!s && r && !periph_ready_n_in |=> s) else $error("end");
  chk_read_bound: assert property ($fell(s) && r |-> ##[1:8] s) else $error("long");
  chk_timeout_rd: assert property (timeout_out |-> done_out && r) else $error("tmo");
  chk_addr_setup: assert property ($fell(s) |-> $stable(a)) else $error("addr");
  chk_data_setup: assert property ($fell(s) && !r |-> $past(periph_data_oe_out) &&
    $stable(periph_data_out)) else $error("data");
  chk_write_len: assert property ($fell(s) && !r |-> !s [*8] ##1 s) else $error("len");
  chk_addr_hold: assert property ($rose(s) |-> $stable(a) ##1 $stable(a)) else $error("hold");
  chk_done_rise: assert property ($rose(s) |-> done_out) else $error("done");
endmodule
bind local_peripheral_bus_master lpb_master_chk u_chk (.clk_in, .rst_n_in, .done_out,
  .timeout_out, .periph_select_n_out, .periph_read_not_write_out, .periph_addr_out,
  .periph_data_out, .periph_data_oe_out, .periph_ready_n_in);

// >>> bench/local_peripheral_bus_master_tb_top.sv
/* Self-checking bench for the peripheral bus master.
   Assumes the peripheral model and the bound checker. */
`timescale 1ns/1ps
module local_peripheral_bus_master_tb_top;
  logic clk_in = 1'b0, rst_n_in = 1'b0, vld = 1'b0, rd = 1'b0;
  logic [11:0] ad = 12'h000;
  logic [7:0] wd = 8'h00;
  logic [3:0] lat = 4'h0;
  wire rdy, done, tmo, sel_n, rnw, oe, rdy_n;
  wire [11:0] pa;
  wire [7:0] rdata, pdo, pdi;
  integer mismatches = 0, total_checks = 0, seed = 92162, n, i;
  // Free-running 40 MHz clock.
  always #12.5 clk_in = ~clk_in;
  local_peripheral_bus_master u_local_peripheral_bus_master (.clk_in, .rst_n_in,
    .req_valid_in(vld), .req_read_in(rd), .req_addr_in(ad), .req_wdata_in(wd),
    .req_ready_out(rdy), .done_out(done), .timeout_out(tmo), .rdata_out(rdata),
    .periph_select_n_out(sel_n), .periph_read_not_write_out(rnw), .periph_addr_out(pa),
    .periph_data_in(pdi), .periph_data_out(pdo), .periph_data_oe_out(oe),
    .periph_ready_n_in(rdy_n));
  lpb_periph_model u_lpb_periph_model (.clk_in, .sel_n_in(sel_n), .addr_in(pa),
    .lat_in(lat), .ready_n_out(rdy_n), .data_out(pdi));
  // A read times out when the model never readies or readies too late.
  function automatic logic exp_tmo(input logic r, input logic [3:0] l);
    return r && (l == 4'h0 || l > 4'h7);
  endfunction
  // Negedges from the taking edge to done: setup, select-low cycles, done.
  function automatic integer exp_len(input logic r, input logic [3:0] l);
    return (!r || exp_tmo(r, l)) ? 10 : l + 3;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One request; a hang counts as a mismatch and ends the run.
  task automatic op(input logic r, input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] l);
    n = 0;
    while (rdy !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    if (rdy !== 1'b1) begin
      mismatches++;
      end_sim;
    end
    rd = r;
    ad = a;
    wd = d;
    lat = l;
    vld = 1'b1;
    n = 0;
    do begin
      @(negedge clk_in);
      vld = 1'b0;
      n++;
    end while (done !== 1'b1 && n < 20);
    if (done !== 1'b1) begin
      mismatches++;
      end_sim;
    end
    check(n, exp_len(r, l));
    check(tmo, exp_tmo(r, l));
    check({rdy, sel_n, oe, rnw}, {2'b01, !r, r});
    check(pa, a);
    if (r) check(rdata, a[7:0] ^ 8'h5a);
    else check(pdo, d);
  endtask
  // Latencies 0 to 9 on reads and writes, then random traffic.
  initial begin
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (i = 0; i < 20; i++) op(i > 9, 12'hfff - 12'(i), 8'h80 >> (i % 8), 4'(i % 10));
    for (i = 0; i < 40; i++) op(1'($random(seed)), 12'($random(seed)), 8'($random(seed)),
      4'($unsigned($random(seed)) % 10));
    end_sim;
  end
endmodule
